// ---- core/pdls_supervisor.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// R1: the whole link function works only while the enable input is 1.
// R2: role input 0 makes a master, 1 makes a slave.
// R3: link address follows the role automatically.
// R4: comm-controlled slave follows master run when units digit is 1.
// R5: slave sends its fault to master only when tens digit is 1.
// R6: master raises offline fault on slave loss only when hundreds digit is 1.
// R7: offline fault is raised only if the loss happens while master runs; the code also raises it when a loss begun while stopped lasts into a run.
// R8: select 0 sends running frequency, or droop frequency when droop is nonzero.
// R9: select 1 sends the target frequency.
// R10: slave uses gain times received plus offset, clamped to +-100.00 %.
// R11: control type 0 corrects frequency command, 1 corrects torque command.
// R12: both roles flag link loss after the detection time without frames.
// R13: detection time zero disables loss detection.
// R14: master sends periodically at the sending period, 1 ms to 10 s.
// R15: speeds are flagged in sync when within the frequency window.
// R16: monitor values are readable in the address window 0x7000 to 0x7044.
// R17: frequency monitors report magnitudes up to 500.00 Hz.
// R18: user keeps droop at zero for load sharing so plain frequency is sent.
// R19: commands are signed fixed point percent with two decimals.
`include "pdls_consts.svh"
module pdls_supervisor
   import pdls_pkg::*;
#(
   parameter int CYC_PER_MS = `PDLS_CLK_HZ / `PDLS_MS_PER_S
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // configuration
   input wire logic PEER_LINK_ENABLE,
   input wire logic ROLE_SELECT,
   input wire logic [2:0] EXCHANGE_OPTIONS,
   input wire logic SEND_DATA_SELECT,
   input wire logic signed [15:0] RECEIVE_ZERO_OFFSET,
   input wire logic signed [15:0] RECEIVE_GAIN,
   input wire logic [6:0] LINK_TIMEOUT_TIME,
   input wire logic [13:0] MASTER_SEND_PERIOD,
   input wire logic [15:0] SYNC_WINDOW,
   input wire logic [1:0] COMMAND_SOURCE,
   input wire logic DROOP_ACTIVE,
   input wire logic CONTROL_TYPE_SELECT,
   // drive state
   input wire logic DRIVE_RUNNING,
   input wire logic DRIVE_FAULT,
   input wire logic signed [15:0] RUN_FREQ,
   input wire logic signed [15:0] DROOP_FREQ,
   input wire logic signed [15:0] TARGET_FREQ,
   input wire logic signed [15:0] OPER_FREQ_HZ,
   input wire logic signed [15:0] SET_FREQ_HZ,
   input wire logic FAULT_CLEAR,
   // link frames
   input wire pdls_frame_t RX_FRAME,
   output pdls_frame_t TX_FRAME,
   output logic [7:0] LINK_ADDR,
   // slave commands and status
   output logic SLAVE_RUN,
   output logic signed [15:0] SLAVE_FREQ_CMD,
   output logic signed [15:0] SLAVE_TORQ_CMD,
   output logic LINK_LOST,
   output logic LINK_OFFLINE_FAULT,
   output logic SLAVE_FAULT_SEEN,
   output logic SPEED_IN_SYNC,
   // monitor read port
   input wire logic MON_RD,
   input wire logic [15:0] MON_ADDR,
   output logic [15:0] MON_DATA,
   output logic MON_ACK,
   output logic MON_ERR
);

   // ***************************************
   // helpers
   // ***************************************
   function automatic logic signed [15:0] scale_clamp(input logic signed [15:0] x,
      input logic signed [15:0] k, input logic signed [15:0] b);
      logic signed [31:0] y;
      y = (32'(x) * 32'(k)) / `PDLS_GAIN_ONE + 32'(b);
      if (y > `PDLS_PCT_MAX) begin
         y = `PDLS_PCT_MAX;
      end else if (y < `PDLS_PCT_MIN) begin
         y = `PDLS_PCT_MIN;
      end
      return y[15:0];
   endfunction

   function automatic logic [15:0] mag_lim(input logic signed [15:0] f);
      logic [15:0] m;
      m = f[15] ? 16'(-f) : 16'(f);
      return (m > `PDLS_FREQ_MAX) ? `PDLS_FREQ_MAX : m;
   endfunction

   // ***************************************
   // state
   // ***************************************
   pdls_state_t q;
   pdls_state_t next_q;
   logic ms_tick;
   logic is_slave;
   logic [13:0] to_limit;
   logic [13:0] period;
   logic signed [16:0] diff;
   logic [15:0] diff_mag;

   always_comb begin
      next_q = q;
      is_slave = (ROLE_SELECT == `PDLS_ROLE_SLAVE); // [R2]
      ms_tick = (q.ms_cnt == 16'(CYC_PER_MS - 1));
      to_limit = 14'(LINK_TIMEOUT_TIME * `PDLS_MS_PER_TO_UNIT);
      period = (MASTER_SEND_PERIOD == 14'h0000) ? 14'h0001 : MASTER_SEND_PERIOD; // [R14]
      diff = 17'(RX_FRAME.value) - 17'(RUN_FREQ);
      diff_mag = diff[16] ? 16'(-diff) : 16'(diff);
      next_q.ms_cnt = ms_tick ? 16'h0000 : q.ms_cnt + 16'h0001;
      next_q.tx.valid = 1'b0;
      next_q.mon_ack = MON_RD;
      // monitor window
      if (MON_RD) begin
         next_q.mon_err = (MON_ADDR < `PDLS_MON_OPER) || (MON_ADDR > `PDLS_MON_LAST); // [R16]
         if (MON_ADDR == `PDLS_MON_OPER) begin
            next_q.mon_data = mag_lim(OPER_FREQ_HZ); // [R17]
         end else if (MON_ADDR == `PDLS_MON_SET) begin
            next_q.mon_data = mag_lim(SET_FREQ_HZ); // [R17]
         end else begin
            next_q.mon_data = 16'h0000;
         end
      end
      if (!PEER_LINK_ENABLE) begin // [R1]
         next_q.send_cnt = 14'h0000;
         next_q.to_cnt = 14'h0000;
         next_q.link_lost = 1'b0;
         next_q.offline_fault = 1'b0;
         next_q.slave_fault_seen = 1'b0;
         next_q.slave_run = 1'b0;
         next_q.in_sync = 1'b0;
         next_q.flt_prev = DRIVE_FAULT;
      end else begin
         next_q.link_addr = is_slave ? `PDLS_ADDR_SLAVE : `PDLS_ADDR_MASTER; // [R3]
         next_q.flt_prev = DRIVE_FAULT;
         // loss detection
         if (LINK_TIMEOUT_TIME == 7'h00) begin // [R13]
            next_q.to_cnt = 14'h0000;
            next_q.link_lost = 1'b0;
         end else if (RX_FRAME.valid) begin // [R12]
            next_q.to_cnt = 14'h0000;
            next_q.link_lost = 1'b0;
         end else if (ms_tick) begin
            if (q.to_cnt >= to_limit - 14'h0001) begin
               next_q.link_lost = 1'b1; // [R12]
            end else begin
               next_q.to_cnt = q.to_cnt + 14'h0001;
            end
         end
         if (!is_slave) begin
            // periodic send
            if (ms_tick) begin
               if (q.send_cnt >= period - 14'h0001) begin // [R14]
                  next_q.send_cnt = 14'h0000;
                  next_q.tx.valid = 1'b1;
                  next_q.tx.run = DRIVE_RUNNING;
                  next_q.tx.fault = 1'b0;
                  if (SEND_DATA_SELECT) begin
                     next_q.tx.value = TARGET_FREQ; // [R9]
                  end else begin
                     next_q.tx.value = DROOP_ACTIVE ? DROOP_FREQ : RUN_FREQ; // [R8] [R19]
                  end
               end else begin
                  next_q.send_cnt = q.send_cnt + 14'h0001;
               end
            end
            // offline fault: set wins over clear
            if (FAULT_CLEAR) begin
               next_q.offline_fault = 1'b0;
               next_q.slave_fault_seen = 1'b0;
            end
            if (EXCHANGE_OPTIONS[`PDLS_XO_OFFLINE] && DRIVE_RUNNING && next_q.link_lost) begin // [R6] [R7]
               next_q.offline_fault = 1'b1;
            end
            if (RX_FRAME.valid && RX_FRAME.fault) begin
               next_q.slave_fault_seen = 1'b1;
            end
            next_q.slave_run = 1'b0;
         end else begin
            next_q.send_cnt = 14'h0000;
            next_q.offline_fault = 1'b0;
            next_q.slave_fault_seen = 1'b0;
            // fault forwarding on fault entry
            if (EXCHANGE_OPTIONS[`PDLS_XO_FAULT] && DRIVE_FAULT && !q.flt_prev) begin // [R5]
               next_q.tx.valid = 1'b1;
               next_q.tx.fault = 1'b1;
               next_q.tx.run = DRIVE_RUNNING;
               next_q.tx.value = RUN_FREQ;
            end
            if (RX_FRAME.valid) begin
               if (COMMAND_SOURCE == `PDLS_SRC_COMM && EXCHANGE_OPTIONS[`PDLS_XO_FOLLOW]) begin // [R4]
                  next_q.slave_run = RX_FRAME.run;
               end
               if (CONTROL_TYPE_SELECT) begin // [R11]
                  next_q.torq_cmd = scale_clamp(RX_FRAME.value, RECEIVE_GAIN, RECEIVE_ZERO_OFFSET); // [R10]
               end else begin
                  next_q.freq_cmd = scale_clamp(RX_FRAME.value, RECEIVE_GAIN, RECEIVE_ZERO_OFFSET); // [R10]
               end
               next_q.in_sync = (diff_mag <= SYNC_WINDOW); // [R15]
            end
            if (!(COMMAND_SOURCE == `PDLS_SRC_COMM && EXCHANGE_OPTIONS[`PDLS_XO_FOLLOW])) begin
               next_q.slave_run = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // ***************************************
   // outputs
   // ***************************************
   assign TX_FRAME = q.tx;
   assign LINK_ADDR = q.link_addr;
   assign SLAVE_RUN = q.slave_run;
   assign SLAVE_FREQ_CMD = q.freq_cmd;
   assign SLAVE_TORQ_CMD = q.torq_cmd;
   assign LINK_LOST = q.link_lost;
   assign LINK_OFFLINE_FAULT = q.offline_fault;
   assign SLAVE_FAULT_SEEN = q.slave_fault_seen;
   assign SPEED_IN_SYNC = q.in_sync;
   assign MON_DATA = q.mon_data;
   assign MON_ACK = q.mon_ack;
   assign MON_ERR = q.mon_err;

   // ***************************************
   // checks
   // ***************************************
   disabled_quiet_a: assert property (@(posedge CLK) disable iff (RST) // [R1]
      !PEER_LINK_ENABLE |=> !TX_FRAME.valid && !LINK_LOST && !LINK_OFFLINE_FAULT)
      else $error("link active while disabled");
   link_addr_a: assert property (@(posedge CLK) disable iff (RST) // [R3]
      !RST && PEER_LINK_ENABLE |=> LINK_ADDR == ($past(ROLE_SELECT) ? `PDLS_ADDR_SLAVE : `PDLS_ADDR_MASTER))
      else $error("link address does not follow role");
   run_follow_a: assert property (@(posedge CLK) disable iff (RST) // [R4]
      PEER_LINK_ENABLE && ROLE_SELECT && RX_FRAME.valid && COMMAND_SOURCE == `PDLS_SRC_COMM
      && EXCHANGE_OPTIONS[`PDLS_XO_FOLLOW] |=> SLAVE_RUN == $past(RX_FRAME.run))
      else $error("slave run does not follow master");
   fault_fwd_a: assert property (@(posedge CLK) disable iff (RST) // [R5]
      TX_FRAME.valid && TX_FRAME.fault |-> $past(EXCHANGE_OPTIONS[`PDLS_XO_FAULT]) && $past(ROLE_SELECT))
      else $error("fault frame sent while forwarding off");
   offline_run_a: assert property (@(posedge CLK) disable iff (RST) // [R7]
      $rose(LINK_OFFLINE_FAULT) |-> $past(DRIVE_RUNNING) && $past(EXCHANGE_OPTIONS[`PDLS_XO_OFFLINE]))
      else $error("offline fault raised while stopped or masked");
   send_select_a: assert property (@(posedge CLK) disable iff (RST) // [R8]
      TX_FRAME.valid && !TX_FRAME.fault |-> TX_FRAME.value == ($past(SEND_DATA_SELECT) ? $past(TARGET_FREQ)
      : ($past(DROOP_ACTIVE) ? $past(DROOP_FREQ) : $past(RUN_FREQ))))
      else $error("wrong frequency sent");
   no_detect_a: assert property (@(posedge CLK) disable iff (RST) // [R13]
      LINK_TIMEOUT_TIME == 7'h00 |=> !LINK_LOST)
      else $error("loss flagged with detection off");
   cmd_clamp_a: assert property (@(posedge CLK) disable iff (RST) // [R10]
      32'(SLAVE_FREQ_CMD) <= `PDLS_PCT_MAX && 32'(SLAVE_FREQ_CMD) >= `PDLS_PCT_MIN
      && 32'(SLAVE_TORQ_CMD) <= `PDLS_PCT_MAX && 32'(SLAVE_TORQ_CMD) >= `PDLS_PCT_MIN)
      else $error("slave command out of range");
   mon_mag_a: assert property (@(posedge CLK) disable iff (RST) // [R17]
      MON_ACK |-> MON_DATA <= `PDLS_FREQ_MAX && MON_ERR == ($past(MON_ADDR) > `PDLS_MON_LAST
      || $past(MON_ADDR) < `PDLS_MON_OPER))
      else $error("monitor read wrong");
endmodule

// ---- shared/pdls_consts.svh ----
`ifndef PDLS_CONSTS_SVH
`define PDLS_CONSTS_SVH
// clock and time base
`define PDLS_CLK_HZ 25000000
`define PDLS_MS_PER_S 1000
// detection time unit is 0.1 s, counted in 1 ms ticks
`define PDLS_MS_PER_TO_UNIT 14'h0064
// fixed point: 0.01 % and 0.01 gain steps
`define PDLS_PCT_MAX 32'sh0000_2710
`define PDLS_PCT_MIN -32'sh0000_2710
`define PDLS_GAIN_ONE 32'sh0000_0064
// monitor window and limits
`define PDLS_MON_OPER 16'h7000
`define PDLS_MON_SET 16'h7001
`define PDLS_MON_LAST 16'h7044
`define PDLS_FREQ_MAX 16'hc350
// roles, sources, addresses
`define PDLS_ROLE_MASTER 1'h0
`define PDLS_ROLE_SLAVE 1'h1
`define PDLS_SRC_COMM 2'h2
`define PDLS_ADDR_MASTER 8'h01
`define PDLS_ADDR_SLAVE 8'h02
// digits of the exchange options
`define PDLS_XO_FOLLOW 0
`define PDLS_XO_FAULT 1
`define PDLS_XO_OFFLINE 2
`endif

// ---- shared/pdls_pkg.sv ----
package pdls_pkg;
   typedef struct packed {
      logic valid;
      logic run;
      logic fault;
      logic signed [15:0] value;
   } pdls_frame_t;

   typedef struct packed {
      logic [15:0] ms_cnt;
      logic [13:0] send_cnt;
      logic [13:0] to_cnt;
      logic link_lost;
      logic offline_fault;
      logic slave_fault_seen;
      logic flt_prev;
      pdls_frame_t tx;
      logic slave_run;
      logic signed [15:0] freq_cmd;
      logic signed [15:0] torq_cmd;
      logic in_sync;
      logic [7:0] link_addr;
      logic [15:0] mon_data;
      logic mon_ack;
      logic mon_err;
   } pdls_state_t;
endpackage

// ---- verification/pdls_peer_model.sv ----
`timescale 1ns/100ps
module pdls_peer_model
   import pdls_pkg::*;
(
   // clock
   input wire logic clk,
   // frames toward the supervisor
   output pdls_frame_t rx_frame
);
   // ****************
   // frame sender
   // ****************
   initial begin
      rx_frame = '0;
   end
   // one frame per call; value is a signed percentage in 0.01 steps
   task automatic send_frame(input logic r, input logic f, input logic signed [15:0] v);
      @(posedge clk);
      rx_frame <= '{valid: 1'b1, run: r, fault: f, value: v};
      @(posedge clk);
      // released fields flip so stale data is never mistaken for a fresh frame
      rx_frame <= '{valid: 1'b0, run: ~r, fault: ~f, value: ~v};
   endtask
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
module testbench;
   import pdls_pkg::*;
   localparam int CPM = 4;
   logic clk = 1'b0, rst = 1'b1, en = 1'b1, role = 1'b0, sds = 1'b0, droop = 1'b0, cts = 1'b0;
   logic run = 1'b0, flt = 1'b0, fclr = 1'b0, mrd = 1'b0, ack, merr, srun, lost, off, fseen, sync;
   logic [2:0] xo = 3'h7;
   logic [6:0] tout = 7'h01;
   logic [13:0] per = 14'h0002;
   logic [1:0] src = 2'h2;
   logic [7:0] addr;
   logic [15:0] win = 16'h0032, maddr = 16'h0000, mdata;
   logic signed [15:0] ofs = 16'sh0064, gain = 16'sh0064, runf = 16'sh04d2, drf = 16'sh0400;
   logic signed [15:0] tgf = 16'sh0700, opf = -16'sh05dc, setf = 16'sh09c4, fcmd, tcmd;
   pdls_frame_t rx, tx;
   int err_total = 0, comparisons = 0, n;
   pdls_supervisor #(.CYC_PER_MS(CPM)) dut (.CLK(clk), .RST(rst), .PEER_LINK_ENABLE(en), .ROLE_SELECT(role),
      .EXCHANGE_OPTIONS(xo), .SEND_DATA_SELECT(sds), .RECEIVE_ZERO_OFFSET(ofs), .RECEIVE_GAIN(gain),
      .LINK_TIMEOUT_TIME(tout), .MASTER_SEND_PERIOD(per), .SYNC_WINDOW(win), .COMMAND_SOURCE(src),
      .DROOP_ACTIVE(droop), .CONTROL_TYPE_SELECT(cts), .DRIVE_RUNNING(run), .DRIVE_FAULT(flt),
      .RUN_FREQ(runf), .DROOP_FREQ(drf), .TARGET_FREQ(tgf), .OPER_FREQ_HZ(opf), .SET_FREQ_HZ(setf),
      .FAULT_CLEAR(fclr), .RX_FRAME(rx), .TX_FRAME(tx), .LINK_ADDR(addr), .SLAVE_RUN(srun),
      .SLAVE_FREQ_CMD(fcmd), .SLAVE_TORQ_CMD(tcmd), .LINK_LOST(lost), .LINK_OFFLINE_FAULT(off),
      .SLAVE_FAULT_SEEN(fseen), .SPEED_IN_SYNC(sync), .MON_RD(mrd), .MON_ADDR(maddr), .MON_DATA(mdata),
      .MON_ACK(ack), .MON_ERR(merr));
   pdls_peer_model peer (.clk(clk), .rx_frame(rx));
   initial begin
      forever #20 clk = ~clk;
   end
   // ****************
   // tasks
   // ****************
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // sel 0 waits for a sent frame, sel 1 for link loss; k counts the edges passed before the one where the event is seen
   task automatic wait_ev(input int sel, input int lim, input bit must, output int k);
      for (k = 0; k < lim; k++) begin
         @(posedge clk);
         #1;
         if ((sel == 0 && tx.valid === 1'b1) || (sel == 1 && lost === 1'b1)) break;
      end
      if (must && k == lim) begin
         err_total++;
         $display("BAD wait %0d expired", sel);
         end_of_test();
      end
   endtask
   task automatic mon(input logic [15:0] a, input logic [15:0] e, input logic er);
      @(posedge clk) mrd <= 1'b1;
      maddr <= a;
      @(posedge clk) mrd <= 1'b0;
      #1 chk("mon ack", 16'h0001, 16'(ack));
      chk("mon data", e, mdata);
      chk("mon err", 16'(er), 16'(merr));
   endtask
   task automatic scaled(input logic c, input logic signed [15:0] k, x, y);
      @(posedge clk) cts <= c;
      gain <= k;
      peer.send_frame(1'b1, 1'b0, x);
      #1 chk("scaled", y, c ? tcmd : fcmd);
   endtask
   // ****************
   // sequence
   // ****************
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      wait_ev(0, 40, 1, n);
      chk("addr master", 16'h0001, 16'(addr));
      chk("tx run", runf, tx.value);
      wait_ev(0, 40, 1, n);
      chk("period", 16'h0007, n[15:0]);
      @(posedge clk) droop <= 1'b1;
      wait_ev(0, 40, 1, n);
      wait_ev(0, 40, 1, n);
      chk("tx droop", drf, tx.value);
      @(posedge clk) sds <= 1'b1;
      wait_ev(0, 40, 1, n);
      wait_ev(0, 40, 1, n);
      chk("tx target", tgf, tx.value);
      peer.send_frame(1'b0, 1'b0, 16'sh0000);
      wait_ev(1, 600, 1, n);
      chk("lost time", 16'h0001, 16'((n >= 392) && (n <= 408)));
      chk("offline stopped", 16'h0000, 16'(off));
      chk("fault unseen", 16'h0000, 16'(fseen));
      @(posedge clk) run <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("offline running", 16'h0001, 16'(off));
      @(posedge clk) fclr <= 1'b1;
      xo <= 3'h3;
      @(posedge clk) fclr <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("offline masked", 16'h0000, 16'(off));
      peer.send_frame(1'b0, 1'b1, 16'sh0000);
      @(posedge clk) tout <= 7'h00;
      #1 chk("lost cleared", 16'h0000, 16'(lost));
      chk("fault seen", 16'h0001, 16'(fseen));
      wait_ev(1, 600, 0, n);
      chk("no detect", 16'h0000, 16'(lost));
      @(posedge clk) fclr <= 1'b1;
      @(posedge clk) fclr <= 1'b0;
      #1 chk("fault cleared", 16'h0000, 16'(fseen));
      mon(16'h7000, 16'h05dc, 1'b0);
      mon(16'h7001, 16'h09c4, 1'b0);
      mon(16'h7044, 16'h0000, 1'b0);
      mon(16'h7045, 16'h0000, 1'b1);
      mon(16'h6fff, 16'h0000, 1'b1);
      @(posedge clk) role <= 1'b1;
      droop <= 1'b0;
      runf <= 16'sh0bb8;
      repeat (2) @(posedge clk);
      #1 chk("addr slave", 16'h0002, 16'(addr));
      scaled(1'b0, 16'sh00c8, 16'sh0bb8, 16'sh17d4);
      chk("run follow", 16'h0001, 16'(srun));
      chk("in sync", 16'h0001, 16'(sync));
      scaled(1'b0, 16'sh00c8, 16'sh1f40, 16'sh2710);
      chk("out of sync", 16'h0000, 16'(sync));
      scaled(1'b0, -16'sh03e8, 16'sh1388, -16'sh2710);
      scaled(1'b1, 16'sh00c8, 16'sh0bb8, 16'sh17d4);
      @(posedge clk) xo <= 3'h2;
      peer.send_frame(1'b1, 1'b0, 16'sh0000);
      #1 chk("run ignored", 16'h0000, 16'(srun));
      @(posedge clk) flt <= 1'b1;
      wait_ev(0, 5, 1, n);
      chk("fault sent", 16'h0001, 16'(tx.fault));
      @(posedge clk) flt <= 1'b0;
      xo <= 3'h0;
      @(posedge clk) flt <= 1'b1;
      wait_ev(0, 20, 0, n);
      chk("fault kept", 16'h0014, n[15:0]);
      @(posedge clk) en <= 1'b0;
      role <= 1'b0;
      wait_ev(0, 40, 0, n);
      chk("disabled tx", 16'h0028, n[15:0]);
      end_of_test();
   end
endmodule
